// *** hdl/attribute_palette_controller.sv ***
// Functional notes
// - Five-bit index picks the attribute register; reads at 3C1h, writes at 3C0h.
// - Writes to 3C0h alternate between index load and data write via a toggle.
// - Reading input status one resets the toggle so the next write loads the index.
// - Outside 256-colour mode a 4-bit pixel selects one of sixteen 6-bit entries.
// - In 256-colour mode entries only form an index into the external colour table.
// - Outside 256-colour mode, palette-mapped output bits 7 and 6 come from colour select bits 3 and 2.
// - Outside 256-colour mode, alternate source bit picks mapped output bits 5:4 from palette or colour select 1:0.
// - Mode bit 0 selects text handling when clear, graphics handling when set.
// - In text handling, mode bit 1 selects colour decoding when clear, monochrome when set.
// - Ninth dot is background, or repeats eighth dot for codes C0h-DFh if enabled.
// - Border colour is output in 80-column modes only, never in 40-column modes.
`timescale 1ns/10ps
`default_nettype none
`include "attr_regs.svh"

module attribute_palette_controller
    import attr_pkg::*;
(
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    // Host I/O port
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [15:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_rdata_valid,
    // Status sources and addressing mode
    input wire logic mono_addressing,
    input wire logic vretrace,
    input wire logic no_display,
    // Pixel stream in
    input wire logic pix_valid,
    input wire logic [3:0] pix_value,
    input wire logic [7:0] char_code,
    input wire logic [3:0] text_fg,
    input wire logic [3:0] text_bg,
    input wire logic glyph_bit,
    input wire logic ninth_dot,
    input wire logic border_area,
    input wire logic column80,
    // Colour out
    output logic [7:0] color_out,
    output logic color_valid,
    // Pixel pan value for the serializer
    output logic [3:0] pixel_pan
);
    // ----------------------------------------
    // Register file state
    // ----------------------------------------
    palette_entry_t pal_q [16];
    palette_entry_t pal_d [16];
    attr_index_t index_q;
    attr_index_t index_d;
    logic source_q;
    logic source_d;
    port_phase_e phase_q;
    port_phase_e phase_d;
    logic [7:0] mode_q;
    logic [7:0] mode_d;
    logic [7:0] border_q;
    logic [7:0] border_d;
    logic [7:0] plane_q;
    logic [7:0] plane_d;
    logic [3:0] pan_q;
    logic [3:0] pan_d;
    logic [3:0] csel_q;
    logic [3:0] csel_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;

    logic [15:0] status_port;
    logic [7:0] indexed_value;

    assign status_port = mono_addressing ? `STATUS_ONE_PORT_MONO : `STATUS_ONE_PORT_COLOR;

    always_comb begin
        indexed_value = 8'h00;
        if (index_q <= `IDX_PALETTE_LAST) begin
            indexed_value = {2'b00, pal_q[index_q[3:0]]};
        end else begin
            case (index_q)
                `IDX_MODE_CONTROL: indexed_value = mode_q;
                `IDX_BORDER_COLOR: indexed_value = border_q;
                `IDX_PLANE_ENABLE: indexed_value = plane_q;
                `IDX_PIXEL_PAN: indexed_value = {4'h0, pan_q};
                `IDX_COLOR_SELECT: indexed_value = {4'h0, csel_q};
                default: indexed_value = 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // Host port next state
    // ----------------------------------------
    always_comb begin
        pal_d = pal_q;
        index_d = index_q;
        source_d = source_q;
        phase_d = phase_q;
        mode_d = mode_q;
        border_d = border_q;
        plane_d = plane_q;
        pan_d = pan_q;
        csel_d = csel_q;
        rdata_d = rdata_q;
        rvalid_d = 1'b0;
        if (io_wr && io_addr == `ATTR_PORT_WRITE) begin
            if (phase_q == PHASE_INDEX) begin
                index_d = io_wdata[4:0];
                source_d = io_wdata[`IDXPORT_SOURCE_BIT];
                phase_d = PHASE_DATA;
            end else begin
                phase_d = PHASE_INDEX;
                if (index_q <= `IDX_PALETTE_LAST) begin
                    // host owns palette only while source bit is clear
                    if (!source_q) begin
                        pal_d[index_q[3:0]] = io_wdata[5:0];
                    end
                end else begin
                    case (index_q)
                        `IDX_MODE_CONTROL: mode_d = io_wdata;
                        `IDX_BORDER_COLOR: border_d = io_wdata;
                        `IDX_PLANE_ENABLE: plane_d = io_wdata;
                        `IDX_PIXEL_PAN: pan_d = io_wdata[3:0];
                        `IDX_COLOR_SELECT: csel_d = io_wdata[3:0];
                        default: ;
                    endcase
                end
            end
        end else if (io_rd) begin
            rvalid_d = 1'b1;
            rdata_d = 8'h00;
            if (io_addr == `ATTR_PORT_WRITE) begin
                rdata_d = {2'b00, source_q, index_q};
            end else if (io_addr == `ATTR_PORT_READ) begin
                rdata_d = indexed_value;
            end else if (io_addr == status_port) begin
                phase_d = PHASE_INDEX;
                rdata_d[`STATUS_NO_DISPLAY_BIT] = no_display;
                rdata_d[`STATUS_VRETRACE_BIT] = vretrace;
            end else begin
                // Undecoded port: no answer and the last read data stays put
                rvalid_d = 1'b0;
                rdata_d = rdata_q;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < 16; i++) begin
                pal_q[i] <= 6'h00;
            end
            index_q <= 5'h00;
            source_q <= 1'b0;
            phase_q <= PHASE_INDEX;
            mode_q <= `RESET_BYTE;
            border_q <= `RESET_BYTE;
            plane_q <= `RESET_PLANE_ENABLE;
            pan_q <= 4'h0;
            csel_q <= 4'h0;
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else if (clk_en) begin
            pal_q <= pal_d;
            index_q <= index_d;
            source_q <= source_d;
            phase_q <= phase_d;
            mode_q <= mode_d;
            border_q <= border_d;
            plane_q <= plane_d;
            pan_q <= pan_d;
            csel_q <= csel_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign io_rdata = rdata_q;
    assign io_rdata_valid = rvalid_q;
    assign pixel_pan = pan_q;

    // ----------------------------------------
    // Pixel path
    // ----------------------------------------
    logic dot_on;
    logic [3:0] pal_sel;
    palette_entry_t entry;
    logic [7:0] mapped;
    logic high_half_q;
    logic high_half_d;
    logic [3:0] high_nib_q;
    logic [3:0] high_nib_d;
    logic [7:0] color_q;
    logic [7:0] color_d;
    logic cvalid_q;
    logic cvalid_d;

    ninth_dot_select u_ninth (
        .mclk(mclk),
        .rst(rst),
        .clk_en(clk_en),
        .dot_valid(pix_valid),
        .char_code(char_code),
        .glyph_bit(glyph_bit),
        .ninth_dot(ninth_dot),
        .line_graphics_enable(mode_q[`MODE_LINE_GFX_BIT]),
        .dot_on(dot_on)
    );

    always_comb begin
        if (mode_q[`MODE_GRAPHICS_BIT]) begin
            pal_sel = pix_value & plane_q[3:0];
        end else if (mode_q[`MODE_MONO_BIT]) begin
            pal_sel = dot_on ? (text_fg[3] ? `MONO_ON_BRIGHT : `MONO_ON_NORMAL) : 4'h0;
        end else begin
            pal_sel = dot_on ? text_fg : text_bg;
        end
        entry = pal_q[pal_sel];
        mapped[7:6] = csel_q[3:2];
        mapped[5:4] = mode_q[`MODE_ALT_SOURCE_BIT] ? csel_q[1:0] : entry[5:4];
        mapped[3:0] = entry[3:0];
    end

    always_comb begin
        color_d = color_q;
        cvalid_d = 1'b0;
        high_half_d = high_half_q;
        high_nib_d = high_nib_q;
        if (pix_valid) begin
            if (border_area) begin
                color_d = column80 ? border_q : 8'h00;
                cvalid_d = 1'b1;
                high_half_d = 1'b0;
            end else if (!source_q) begin
                // display path idle while host owns palette
                color_d = 8'h00;
                cvalid_d = 1'b1;
                high_half_d = 1'b0;
            end else if (mode_q[`MODE_WIDE_PIXEL_BIT]) begin
                // two mapped nibbles form one table index
                if (!high_half_q) begin
                    high_nib_d = entry[3:0];
                    high_half_d = 1'b1;
                end else begin
                    color_d = {high_nib_q, entry[3:0]};
                    cvalid_d = 1'b1;
                    high_half_d = 1'b0;
                end
            end else begin
                color_d = mapped;
                cvalid_d = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            color_q <= 8'h00;
            cvalid_q <= 1'b0;
            high_half_q <= 1'b0;
            high_nib_q <= 4'h0;
        end else if (clk_en) begin
            color_q <= color_d;
            cvalid_q <= cvalid_d;
            high_half_q <= high_half_d;
            high_nib_q <= high_nib_d;
        end
    end

    assign color_out = color_q;
    assign color_valid = cvalid_q;
endmodule : attribute_palette_controller

`default_nettype wire

// *** hdl/attr_regs.svh ***
`ifndef ATTR_REGS_SVH
`define ATTR_REGS_SVH

// ----------------------------------------
// Host I/O ports
// ----------------------------------------
`define ATTR_PORT_WRITE 16'h03C0
`define ATTR_PORT_READ 16'h03C1
`define STATUS_ONE_PORT_MONO 16'h03BA
`define STATUS_ONE_PORT_COLOR 16'h03DA

// ----------------------------------------
// Attribute register indices
// ----------------------------------------
`define IDX_PALETTE_LAST 5'h0F
`define IDX_MODE_CONTROL 5'h10
`define IDX_BORDER_COLOR 5'h11
`define IDX_PLANE_ENABLE 5'h12
`define IDX_PIXEL_PAN 5'h13
`define IDX_COLOR_SELECT 5'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define IDXPORT_SOURCE_BIT 5
`define MODE_GRAPHICS_BIT 0
`define MODE_MONO_BIT 1
`define MODE_LINE_GFX_BIT 2
`define MODE_WIDE_PIXEL_BIT 6
`define MODE_ALT_SOURCE_BIT 7
`define STATUS_NO_DISPLAY_BIT 0
`define STATUS_VRETRACE_BIT 3

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define RESET_BYTE 8'h00
`define RESET_PLANE_ENABLE 8'h0F
`define LINE_GFX_FIRST 8'hC0
`define LINE_GFX_LAST 8'hDF
`define MONO_ON_BRIGHT 4'hF
`define MONO_ON_NORMAL 4'h7

`endif

// *** hdl/attr_pkg.sv ***
package attr_pkg;
    typedef logic [5:0] palette_entry_t;
    typedef logic [4:0] attr_index_t;
    typedef enum logic {
        PHASE_INDEX,
        PHASE_DATA
    } port_phase_e;
endpackage : attr_pkg

// *** hdl/ninth_dot_select.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "attr_regs.svh"

module ninth_dot_select (
    // Clock and control
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic dot_valid,
    // Dot inputs
    input wire logic [7:0] char_code,
    input wire logic glyph_bit,
    input wire logic ninth_dot,
    input wire logic line_graphics_enable,
    // Result: foreground selected
    output logic dot_on
);
    logic eighth_q;
    logic eighth_d;
    logic is_line_char;

    assign is_line_char = (char_code >= `LINE_GFX_FIRST) && (char_code <= `LINE_GFX_LAST);

    // Ninth dot never comes from the font, only from the eighth dot or background
    always_comb begin
        eighth_d = eighth_q;
        if (dot_valid && !ninth_dot) begin
            eighth_d = glyph_bit;
        end
        if (!ninth_dot) begin
            dot_on = glyph_bit;
        end else if (line_graphics_enable && is_line_char) begin
            dot_on = eighth_q;
        end else begin
            dot_on = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            eighth_q <= 1'b0;
        end else if (clk_en) begin
            eighth_q <= eighth_d;
        end
    end
endmodule : ninth_dot_select

`default_nettype wire

// *** verif/attr_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "attr_regs.svh"
module attr_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    // Host port and status
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [15:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic io_rdata_valid,
    input wire logic mono_addressing,
    input wire logic vretrace,
    input wire logic no_display,
    // Pixel path
    input wire logic pix_valid,
    input wire logic border_area,
    input wire logic column80,
    input wire logic [7:0] color_out,
    input wire logic color_valid
);
    logic ph_q, ph_d, st_rd, wr0, rd0, rd1;
    logic [5:0] idx_q, idx_d;
    logic [15:0] st_port;
    assign st_port = mono_addressing ? `STATUS_ONE_PORT_MONO : `STATUS_ONE_PORT_COLOR;
    assign st_rd = clk_en && io_rd && !io_wr && io_addr == st_port;
    assign wr0 = clk_en && io_wr && io_addr == `ATTR_PORT_WRITE;
    assign rd0 = clk_en && io_rd && !io_wr && io_addr == `ATTR_PORT_WRITE;
    assign rd1 = clk_en && io_rd && !io_wr && io_addr == `ATTR_PORT_READ;
    // Shadow of the index/data toggle
    always_comb begin
        ph_d = ph_q;
        idx_d = idx_q;
        if (st_rd) begin
            ph_d = 1'b0;
        end else if (wr0) begin
            ph_d = !ph_q;
            if (!ph_q) begin
                idx_d = io_wdata[5:0];
            end
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            ph_q <= 1'b0;
            idx_q <= 6'h00;
        end else begin
            ph_q <= ph_d;
            idx_q <= idx_d;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_status_rd;
        st_rd;
    endsequence
    property p_status;
        s_status_rd |=> io_rdata_valid && io_rdata == {4'h0, $past(vretrace), 2'h0, $past(no_display)};
    endproperty
    a_status: assert property (p_status) else $error("status read data wrong");
    property p_idx_rd;
        rd0 |=> io_rdata_valid && io_rdata == {2'h0, idx_q};
    endproperty
    a_idx_rd: assert property (p_idx_rd) else $error("index readback wrong");
    property p_data_rd;
        rd1 |=> io_rdata_valid;
    endproperty
    a_data_rd: assert property (p_data_rd) else $error("data read gave no answer");
    property p_undecoded;
        clk_en && io_rd && io_addr == 16'h03C2 |=> !io_rdata_valid;
    endproperty
    a_undecoded: assert property (p_undecoded) else $error("undecoded port answered");
    property p_wr_silent;
        clk_en && io_wr |=> !io_rdata_valid;
    endproperty
    a_wr_silent: assert property (p_wr_silent) else $error("write produced read valid");
    property p_rdata_hold;
        !(clk_en && io_rd) |=> $stable(io_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_no_pix;
        clk_en && !pix_valid |=> !color_valid;
    endproperty
    a_no_pix: assert property (p_no_pix) else $error("colour without pixel");
    property p_border40;
        clk_en && pix_valid && border_area && !column80 |=> color_out == 8'h00;
    endproperty
    a_border40: assert property (p_border40) else $error("border in 40 columns");
endmodule : attr_chk
bind attribute_palette_controller attr_chk u_chk (.mclk(mclk), .rst(rst), .clk_en(clk_en), .io_wr(io_wr),
    .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_rdata_valid(io_rdata_valid), .mono_addressing(mono_addressing), .vretrace(vretrace),
    .no_display(no_display), .pix_valid(pix_valid), .border_area(border_area), .column80(column80),
    .color_out(color_out), .color_valid(color_valid));
`default_nettype wire

// *** verif/host_io.sv ***
`timescale 1ns/10ps
`default_nettype none
module host_io (
    // Clock and answer
    input wire logic mclk,
    input wire logic [7:0] io_rdata,
    input wire logic io_rdata_valid,
    // Requests
    output logic io_wr,
    output logic io_rd,
    output logic [15:0] io_addr,
    output logic [7:0] io_wdata
);
    initial begin
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_addr = 16'h0000;
        io_wdata = 8'h00;
    end
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        io_wr <= 1'b1;
        io_addr <= a;
        io_wdata <= d;
        @(posedge mclk);
        io_wr <= 1'b0;
        io_wdata <= ~d;
        @(posedge mclk);
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
        io_rd <= 1'b1;
        io_addr <= a;
        @(posedge mclk);
        io_rd <= 1'b0;
        @(posedge mclk);
        v = io_rdata_valid;
        d = io_rdata;
    endtask : rd
endmodule : host_io
`default_nettype wire

// *** verif/attribute_palette_controller_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module attribute_palette_controller_tb;
    logic mclk, rst, clk_en, io_wr, io_rd, io_rdata_valid, mono_addressing, vretrace, no_display;
    logic pix_valid, glyph_bit, ninth_dot, border_area, column80, color_valid, v;
    logic [15:0] io_addr;
    logic [7:0] io_wdata, io_rdata, char_code, color_out, d;
    logic [3:0] pix_value, text_fg, text_bg, pixel_pan;
    logic [7:0] codes [4] = '{8'hC0, 8'hDF, 8'hBF, 8'hE0};
    logic [7:0] nexp [4] = '{8'hC9, 8'hC9, 8'hDD, 8'hDD};
    int checks = 0;
    int n_mismatch = 0;
    attribute_palette_controller DUT (.mclk(mclk), .rst(rst), .clk_en(clk_en), .io_wr(io_wr), .io_rd(io_rd),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
        .mono_addressing(mono_addressing), .vretrace(vretrace), .no_display(no_display),
        .pix_valid(pix_valid), .pix_value(pix_value), .char_code(char_code), .text_fg(text_fg),
        .text_bg(text_bg), .glyph_bit(glyph_bit), .ninth_dot(ninth_dot), .border_area(border_area),
        .column80(column80), .color_out(color_out), .color_valid(color_valid), .pixel_pan(pixel_pan));
    host_io host (.mclk(mclk), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid), .io_wr(io_wr),
        .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wreg(input logic [7:0] i, input logic [7:0] x);
        host.wr(16'h03C0, i);
        host.wr(16'h03C0, x);
    endtask : wreg
    task automatic px(input logic [3:0] pv, input logic g, input logic n, input logic [7:0] e);
        pix_value <= pv;
        glyph_bit <= g;
        ninth_dot <= n;
        pix_valid <= 1'b1;
        @(posedge mclk);
        pix_valid <= 1'b0;
        @(posedge mclk);
        chk({7'h00, color_valid}, 8'h01);
        chk(color_out, e);
    endtask : px
    task automatic conclude;
        $display("Checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        #200000;
        n_mismatch++;
        conclude();
    end
    initial begin
        {rst, clk_en, mono_addressing, vretrace, no_display, pix_valid} = 6'h30;
        {glyph_bit, ninth_dot, border_area, column80, pix_value, char_code} = 16'h0000;
        {text_fg, text_bg} = 8'h27;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        // Registers
        vretrace <= 1'b1;
        host.rd(16'h03DA, d, v); chk(d, 8'h08);
        wreg(8'h10, 8'h81);
        host.rd(16'h03C1, d, v); chk(d, 8'h81);
        host.rd(16'h03C0, d, v); chk(d, 8'h10);
        host.wr(16'h03C0, 8'h12);
        host.rd(16'h03C1, d, v); chk(d, 8'h0F);
        host.rd(16'h03DA, d, v);
        wreg(8'h11, 8'h5A);
        host.rd(16'h03C1, d, v); chk(d, 8'h5A);
        wreg(8'h15, 8'hFF);
        host.rd(16'h03C1, d, v); chk(d, 8'h00);
        host.rd(16'h03C2, d, v); chk({7'h00, v}, 8'h00);
        mono_addressing <= 1'b1;
        no_display <= 1'b1;
        host.rd(16'h03BA, d, v); chk(d, 8'h09);
        mono_addressing <= 1'b0;
        wreg(8'h13, 8'hA9);
        chk({4'h0, pixel_pan}, 8'h09);
        host.rd(16'h03C1, d, v); chk(d, 8'h09);
        // Frozen clock enable: both port writes must be ignored
        clk_en <= 1'b0;
        wreg(8'h13, 8'h05);
        clk_en <= 1'b1;
        host.rd(16'h03C1, d, v); chk(d, 8'h09);
        chk({4'h0, pixel_pan}, 8'h09);
        $display("Test registers done");
        // Palette path
        for (int i = 0; i < 16; i++) wreg(8'(i), 8'(i * 4 + 1));
        wreg(8'h14, 8'h0E);
        wreg(8'h20, 8'h3F);
        host.rd(16'h03C1, d, v); chk(d, 8'h01);
        wreg(8'h30, 8'h01);
        for (int i = 0; i < 16; i++) px(4'(i), 1'b0, 1'b0, 8'hC0 | 8'(i * 4 + 1));
        wreg(8'h30, 8'h81);
        px(4'h5, 1'b0, 1'b0, 8'hE5);
        // Wide pixels: first mapped nibble alone gives no colour
        wreg(8'h30, 8'h41);
        pix_value <= 4'h2;
        pix_valid <= 1'b1;
        @(posedge mclk);
        pix_valid <= 1'b0;
        @(posedge mclk);
        chk({7'h00, color_valid}, 8'h00);
        px(4'h3, 1'b0, 1'b0, 8'h9D);
        wreg(8'h30, 8'h01);
        wreg(8'h32, 8'h03);
        px(4'hF, 1'b0, 1'b0, 8'hCD);
        border_area <= 1'b1;
        column80 <= 1'b1;
        px(4'h0, 1'b0, 1'b0, 8'h5A);
        column80 <= 1'b0;
        px(4'h0, 1'b0, 1'b0, 8'h00);
        border_area <= 1'b0;
        $display("Test palette done");
        // Text, mono and ninth dot
        wreg(8'h30, 8'h00);
        px(4'h0, 1'b1, 1'b0, 8'hC9);
        px(4'h0, 1'b0, 1'b0, 8'hDD);
        wreg(8'h30, 8'h02);
        text_fg <= 4'hF;
        px(4'h0, 1'b1, 1'b0, 8'hFD);
        px(4'h0, 1'b0, 1'b0, 8'hC1);
        text_fg <= 4'h2;
        wreg(8'h30, 8'h04);
        for (int i = 0; i < 4; i++) begin
            char_code <= codes[i];
            px(4'h0, 1'b1, 1'b0, 8'hC9);
            px(4'h0, 1'b0, 1'b1, nexp[i]);
        end
        wreg(8'h30, 8'h00);
        char_code <= 8'hC0;
        px(4'h0, 1'b1, 1'b0, 8'hC9);
        px(4'h0, 1'b0, 1'b1, 8'hDD);
        wreg(8'h10, 8'h00);
        px(4'h0, 1'b1, 1'b0, 8'h00);
        $display("Test text done");
        conclude();
    end
endmodule : attribute_palette_controller_tb
`default_nettype wire
